/* File: src/uevp_top.sv */
// Decided for this implementation: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
// Contract
// - error enable has seven writable bits
// - enable bit gates its error; resets zero
// - turnaround timeout enable sits at bit four
// - bit one gates crc5 or end-of-frame by role
// - summary flag only from enabled errors
// - sixteen endpoint registers, low byte only
// - endpoint zero bit seven enables low-speed
// - bit six set suppresses nak retries
// - those two bits only endpoint zero, host
// - bit four blocks setup when bidirectional
// - bit four ignored unless both directions
// - bit three receive, bit two transmit
// - bit one reads one when stalled
// - bit zero enables handshake packets
// - generator off holds output at idle level
// - polarity bit nine selects active low
// - bit eight runs or stops the counter
module uevp_top
   import uevp_pkg::*;
(
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [7:0]       wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   input  wire uevp_err_evt_type err_evt,
   input  wire uevp_token_type   token,
   input  wire logic             stall_evt,
   input  wire logic [3:0]       stall_ep,
   output uevp_verdict_type      verdict,
   output logic                  usb_error_summary_flag,
   output logic                  low_speed_direct_connect,
   output logic                  nak_retry_disable,
   output logic                  vbus_pwm_out,
   output logic                  irq
);

   // merge a write into a 16-bit register through byte lanes and a bit mask
   function automatic logic [15:0] wmerge(input logic [15:0] old_v,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel,
                                          input logic [15:0] msk);
      logic [15:0] lane;
      lane = {{8{sel[1]}}, {8{sel[0]}}};
      wmerge = ((old_v & ~lane) | (dat[15:0] & lane)) & msk;
   endfunction

   // true when an address hits an endpoint word
   function automatic logic ep_hit(input logic [7:0] adr);
      ep_hit = (adr[7:6] == UEVP_ADR_EP_BASE[7:6]) && (adr[1:0] == 2'b00);
   endfunction

   // bus slave state
   logic        ack_r, ack_nxt;           // one-cycle answer
   logic [31:0] rdat_r, rdat_nxt;         // read data shown with ack
   // registers
   logic [15:0] err_en_r, err_en_nxt;     // usb_error_irq_enable
   logic [15:0] err_flag_r, err_flag_nxt; // usb_error_flag_status
   logic [15:0] pwm_r, pwm_nxt;           // usb_vbus_pwm_control
   logic [7:0]  duty_r, duty_nxt;         // duty compare
   logic        host_r, host_nxt;         // 1 = host role
   logic [15:0] ep_r   [16];              // usb_endpoint_control
   logic [15:0] ep_nxt [16];
   logic [15:0] ist_r, ist_nxt;           // interrupt status
   logic [15:0] imsk_r, imsk_nxt;         // interrupt mask
   // derived outputs
   logic             sum_r, sum_nxt;
   logic             low_speed_direct_connect_r, low_speed_direct_connect_nxt;
   logic             rdis_r, rdis_nxt;
   logic [7:0]       cnt_r, cnt_nxt;      // generator counter
   logic             pwm_o_r, pwm_o_nxt;
   logic             irq_r, irq_nxt;
   uevp_verdict_type vd_r, vd_nxt;

   // request decode
   logic        req, wr_go, rd_go;
   logic [15:0] err_raw, err_new;
   logic [15:0] ep_sel;
   logic [15:0] ep_tok;

   assign req   = wb_cyc_i & wb_stb_i;
   assign wr_go = req & wb_we_i & ack_r;   // write lands on the ack edge
   assign rd_go = req & ~wb_we_i & ack_r;  // read side effects on the ack edge

   // raw error vector in register layout, bit 1 picked by role
   always_comb
   begin
      err_raw = 16'h0000;
      err_raw[7] = err_evt.bitstuff;
      err_raw[5] = err_evt.dma;
      err_raw[4] = err_evt.turnaround;
      err_raw[3] = err_evt.field_size;
      err_raw[2] = err_evt.data_crc;
      err_raw[UEVP_ERR_EOF] = host_r ? err_evt.frame_end : err_evt.token_crc;
      err_raw[0] = err_evt.pid;
      err_new = err_raw & err_en_r;
   end

   // bus answer and read mux
   always_comb
   begin
      ack_nxt  = req & ~ack_r;
      rdat_nxt = 32'h0000_0000;  // unmapped addresses read zero
      if (req & ~ack_r & ~wb_we_i)
      begin
         if (ep_hit(wb_adr_i))
         begin
            rdat_nxt[15:0] = ep_r[wb_adr_i[5:2]];
            if (wb_adr_i[5:2] == 4'h0 && !host_r)
            begin
               // low-speed and retry bits hidden outside host role
               rdat_nxt[UEVP_EP_LOW_SPEED_DIRECT_CONNECT]  = 1'b0;
               rdat_nxt[UEVP_EP_RETRY] = 1'b0;
            end
         end
         else
         begin
            unique case (wb_adr_i)
               UEVP_ADR_ERR_EN:   rdat_nxt[15:0] = err_en_r;
               UEVP_ADR_ERR_FLAG: rdat_nxt[15:0] = err_flag_r;
               UEVP_ADR_PWM_CTRL: rdat_nxt[15:0] = pwm_r;
               UEVP_ADR_IRQ_STAT: rdat_nxt[15:0] = ist_r;
               UEVP_ADR_IRQ_MASK: rdat_nxt[15:0] = imsk_r;
               UEVP_ADR_MODE:     rdat_nxt[0]    = host_r;
               UEVP_ADR_PWM_DUTY: rdat_nxt[7:0]  = duty_r;
               default:           rdat_nxt       = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         ack_r  <= 1'b0;
         rdat_r <= 32'h0000_0000;
      end
      else
      begin
         ack_r  <= ack_nxt;
         rdat_r <= rdat_nxt;
      end
   end

   // control registers written by software
   always_comb
   begin
      err_en_nxt = err_en_r;
      pwm_nxt    = pwm_r;
      duty_nxt   = duty_r;
      host_nxt   = host_r;
      imsk_nxt   = imsk_r;
      if (wr_go)
      begin
         unique case (wb_adr_i)
            UEVP_ADR_ERR_EN:
               err_en_nxt = wmerge(err_en_r, wb_dat_i, wb_sel_i, UEVP_ERR_EN_MASK);
            UEVP_ADR_PWM_CTRL:
               pwm_nxt = wmerge(pwm_r, wb_dat_i, wb_sel_i, UEVP_PWM_MASK);
            UEVP_ADR_IRQ_MASK:
               imsk_nxt = wmerge(imsk_r, wb_dat_i, wb_sel_i, UEVP_IRQ_MASK_W);
            UEVP_ADR_MODE:
               host_nxt = wb_sel_i[0] ? wb_dat_i[0] : host_r;
            UEVP_ADR_PWM_DUTY:
               duty_nxt = wb_sel_i[0] ? wb_dat_i[7:0] : duty_r;
            default:
               ; // other addresses take no control write
         endcase
      end
   end

   // error flags: hardware sets, write one clears, set wins
   always_comb
   begin
      err_flag_nxt = err_flag_r;
      if (wr_go && wb_adr_i == UEVP_ADR_ERR_FLAG && wb_sel_i[0])
         err_flag_nxt = err_flag_r & ~{8'h00, wb_dat_i[7:0]};
      err_flag_nxt = (err_flag_nxt | err_raw) & UEVP_ERR_EN_MASK;
      // summary flag follows only the enabled flags
      sum_nxt = |(err_flag_nxt & err_en_nxt);
   end

   // endpoint registers; hardware stall wins over a software clear
   always_comb
   begin
      for (int i = 0; i < 16; i++)
      begin
         ep_sel[i] = wr_go && ep_hit(wb_adr_i) && (wb_adr_i[5:2] == 4'(i));
         ep_nxt[i] = ep_r[i];
         if (ep_sel[i])
         begin
            if (i == 0)
               ep_nxt[i] = wmerge(ep_r[i], wb_dat_i, wb_sel_i, UEVP_EP0_MASK);
            else
               ep_nxt[i] = wmerge(ep_r[i], wb_dat_i, wb_sel_i, UEVP_EPN_MASK);
            if (i == 0 && !host_r)
            begin
               // keep host-only bits untouched from device role
               ep_nxt[i][UEVP_EP_LOW_SPEED_DIRECT_CONNECT]  = ep_r[i][UEVP_EP_LOW_SPEED_DIRECT_CONNECT];
               ep_nxt[i][UEVP_EP_RETRY] = ep_r[i][UEVP_EP_RETRY];
            end
         end
         if (stall_evt && stall_ep == 4'(i))
            ep_nxt[i][UEVP_EP_STALL] = 1'b1;
      end
   end

   // token verdict from the addressed endpoint
   always_comb
   begin
      logic bidir;
      bidir  = ep_r[token.ep][UEVP_EP_RXEN] & ep_r[token.ep][UEVP_EP_TXEN];
      ep_tok = ep_r[token.ep];
      vd_nxt           = '0;
      vd_nxt.valid     = token.valid;
      vd_nxt.rx_ok     = token.valid & ~token.is_in & ~token.setup & ep_tok[UEVP_EP_RXEN];
      vd_nxt.tx_ok     = token.valid & token.is_in & ep_tok[UEVP_EP_TXEN];
      // setup needs both directions and the disable bit clear
      vd_nxt.setup_ok  = token.valid & token.setup & bidir & ~ep_tok[UEVP_EP_CONDIS];
      vd_nxt.stalled   = token.valid & ep_tok[UEVP_EP_STALL];
      vd_nxt.handshake = token.valid & ep_tok[UEVP_EP_HSHK];
   end

   // host-only endpoint zero outputs
   always_comb
   begin
      low_speed_direct_connect_nxt = host_r & ep_r[0][UEVP_EP_LOW_SPEED_DIRECT_CONNECT];
      rdis_nxt = host_r & ep_r[0][UEVP_EP_RETRY];
   end

   // vbus generator: counter runs and wraps while bits fifteen and eight are both set, compare against duty
   always_comb
   begin
      logic active;
      active = pwm_r[UEVP_PWM_EN] && (cnt_r < duty_r);
      cnt_nxt = cnt_r;
      if (!pwm_r[UEVP_PWM_EN])
         cnt_nxt = 8'h00;                         // idle generator restarts from zero
      else if (pwm_r[UEVP_PWM_CNT])
         cnt_nxt = cnt_r + 8'h01;
      // xor with polarity: active-low output idles high
      pwm_o_nxt = active ^ pwm_r[UEVP_PWM_POL];
   end

   // interrupt status: sticky, read clears, a new event wins
   always_comb
   begin
      logic [15:0] ev;
      ev = 16'h0000;
      ev[UEVP_IRQ_ERR]   = |err_new;
      ev[UEVP_IRQ_STALL] = stall_evt;
      ev[UEVP_IRQ_SETUP] = token.valid & token.setup & ~vd_nxt.setup_ok;
      ist_nxt = ist_r;
      if (rd_go && wb_adr_i == UEVP_ADR_IRQ_STAT)
         ist_nxt = 16'h0000;
      ist_nxt = ist_nxt | ev;
      irq_nxt = |(ist_nxt & imsk_nxt);
   end

   // register everything
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         err_en_r   <= UEVP_RST_REG;
         err_flag_r <= UEVP_RST_REG;
         pwm_r      <= UEVP_RST_REG;
         duty_r     <= UEVP_RST_DUTY;
         host_r     <= 1'b0;
         imsk_r     <= UEVP_RST_REG;
         ist_r      <= UEVP_RST_REG;
         for (int i = 0; i < 16; i++)
            ep_r[i] <= UEVP_RST_REG;
         sum_r      <= 1'b0;
         low_speed_direct_connect_r     <= 1'b0;
         rdis_r     <= 1'b0;
         cnt_r      <= 8'h00;
         pwm_o_r    <= 1'b0;
         irq_r      <= 1'b0;
         vd_r       <= '0;
      end
      else
      begin
         err_en_r   <= err_en_nxt;
         err_flag_r <= err_flag_nxt;
         pwm_r      <= pwm_nxt;
         duty_r     <= duty_nxt;
         host_r     <= host_nxt;
         imsk_r     <= imsk_nxt;
         ist_r      <= ist_nxt;
         for (int i = 0; i < 16; i++)
            ep_r[i] <= ep_nxt[i];
         sum_r      <= sum_nxt;
         low_speed_direct_connect_r     <= low_speed_direct_connect_nxt;
         rdis_r     <= rdis_nxt;
         cnt_r      <= cnt_nxt;
         pwm_o_r    <= pwm_o_nxt;
         irq_r      <= irq_nxt;
         vd_r       <= vd_nxt;
      end
   end

   assign wb_ack_o                 = ack_r;
   assign wb_dat_o                 = rdat_r;
   assign verdict                  = vd_r;
   assign usb_error_summary_flag   = sum_r;
   assign low_speed_direct_connect = low_speed_direct_connect_r;
   assign nak_retry_disable        = rdis_r;
   assign vbus_pwm_out             = pwm_o_r;
   assign irq                      = irq_r;
   // checks
   property p_err_en_bits;
      @(posedge mclk) disable iff (rst) (err_en_r & ~UEVP_ERR_EN_MASK) == 16'h0000;
   endproperty
   a_err_en_bits: assert property (p_err_en_bits) else $error("error enable bad bits");

   property p_masked_no_sum;
      @(posedge mclk) disable iff (rst)
         (err_en_r == 16'h0000 && err_en_nxt == 16'h0000) |=> !usb_error_summary_flag;
   endproperty
   a_masked_no_sum: assert property (p_masked_no_sum) else $error("summary from masked");

   property p_turn_sets;
      @(posedge mclk) disable iff (rst)
         (err_evt.turnaround && err_en_r[4] && err_en_nxt[4]) |=> usb_error_summary_flag;
   endproperty
   a_turn_sets: assert property (p_turn_sets) else $error("timeout not flagged");

   property p_bit1_role;
      @(posedge mclk) disable iff (rst)
         (host_r && err_evt.token_crc && !err_evt.frame_end && !err_flag_r[1]) |=> !err_flag_r[1];
   endproperty
   a_bit1_role: assert property (p_bit1_role) else $error("crc5 flagged in host");

   property p_ep_high_zero;
      @(posedge mclk) disable iff (rst) ep_r[5][15:5] == 11'h000;
   endproperty
   a_ep_high_zero: assert property (p_ep_high_zero) else $error("endpoint bits stuck");

   property p_low_speed_direct_connect_dev;
      @(posedge mclk) disable iff (rst) !host_r |=> !low_speed_direct_connect;
   endproperty
   a_low_speed_direct_connect_dev: assert property (p_low_speed_direct_connect_dev) else $error("low speed in device");

   property p_retry;
      @(posedge mclk) disable iff (rst)
         $stable(host_r) |=> nak_retry_disable == ($past(host_r) && $past(ep_r[0][6]));
   endproperty
   a_retry: assert property (p_retry) else $error("retry disable wrong");

   property p_setup;
      @(posedge mclk) disable iff (rst)
         token.valid && token.setup && ep_tok[4] && ep_tok[3] && ep_tok[2]
         |=> verdict.valid && !verdict.setup_ok;
   endproperty
   a_setup: assert property (p_setup) else $error("setup not blocked");

   property p_setup_ign;
      @(posedge mclk) disable iff (rst)
         token.valid && token.setup && !(ep_tok[3] && ep_tok[2]) |=> !verdict.setup_ok;
   endproperty
   a_setup_ign: assert property (p_setup_ign) else $error("setup on one-way ep");

   property p_stall_set;
      @(posedge mclk) disable iff (rst) stall_evt && stall_ep == 4'h5 |=> ep_r[5][1];
   endproperty
   a_stall_set: assert property (p_stall_set) else $error("stall lost");

   property p_pwm_idle;
      @(posedge mclk) disable iff (rst)
         !pwm_r[15] |=> vbus_pwm_out == $past(pwm_r[9]);
   endproperty
   a_pwm_idle: assert property (p_pwm_idle) else $error("idle level wrong");

   property p_cnt_hold;
      @(posedge mclk) disable iff (rst)
         pwm_r[15] && !pwm_r[8] && $stable(pwm_r) |=> $stable(cnt_r);
   endproperty
   a_cnt_hold: assert property (p_cnt_hold) else $error("counter ran");

   property p_ack_once;
      @(posedge mclk) disable iff (rst) wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack held");

   c_write: cover property (@(posedge mclk) disable iff (rst) wr_go);
   c_irq: cover property (@(posedge mclk) disable iff (rst) $rose(irq));
   c_setup: cover property (@(posedge mclk) disable iff (rst) verdict.setup_ok);
   c_pwm: cover property (@(posedge mclk) disable iff (rst) $rose(vbus_pwm_out));

endmodule

/* File: src/uevp_pkg.sv */
package uevp_pkg;

   // register byte addresses on the wishbone slave
   localparam logic [7:0] UEVP_ADR_ERR_EN    = 8'h00; // usb_error_irq_enable
   localparam logic [7:0] UEVP_ADR_ERR_FLAG  = 8'h04; // usb_error_flag_status
   localparam logic [7:0] UEVP_ADR_PWM_CTRL  = 8'h08; // usb_vbus_pwm_control
   localparam logic [7:0] UEVP_ADR_IRQ_STAT  = 8'h0C; // sticky events, read clears
   localparam logic [7:0] UEVP_ADR_IRQ_MASK  = 8'h10; // same layout as status
   localparam logic [7:0] UEVP_ADR_MODE      = 8'h14; // operating role
   localparam logic [7:0] UEVP_ADR_PWM_DUTY  = 8'h18; // generator duty compare
   localparam logic [7:0] UEVP_ADR_EP_BASE   = 8'h40; // endpoint 0..15, one word each

   // writable masks, every other bit reads zero
   localparam logic [15:0] UEVP_ERR_EN_MASK  = 16'h00BF;
   localparam logic [15:0] UEVP_EP0_MASK     = 16'h00DF;
   localparam logic [15:0] UEVP_EPN_MASK     = 16'h001F;
   localparam logic [15:0] UEVP_PWM_MASK     = 16'h8300;
   localparam logic [15:0] UEVP_IRQ_MASK_W   = 16'h0007;

   // field positions
   localparam int UEVP_EP_LOW_SPEED_DIRECT_CONNECT   = 7;
   localparam int UEVP_EP_RETRY  = 6;
   localparam int UEVP_EP_CONDIS = 4;
   localparam int UEVP_EP_RXEN   = 3;
   localparam int UEVP_EP_TXEN   = 2;
   localparam int UEVP_EP_STALL  = 1;
   localparam int UEVP_EP_HSHK   = 0;
   localparam int UEVP_PWM_EN    = 15;
   localparam int UEVP_PWM_POL   = 9;
   localparam int UEVP_PWM_CNT   = 8;
   localparam int UEVP_ERR_EOF   = 1;
   localparam int UEVP_IRQ_ERR   = 0;
   localparam int UEVP_IRQ_STALL = 1;
   localparam int UEVP_IRQ_SETUP = 2;

   // reset values
   localparam logic [15:0] UEVP_RST_REG  = 16'h0000;
   localparam logic [7:0]  UEVP_RST_DUTY = 8'h80;

   // error events from the link, one-cycle pulses
   typedef struct packed {
      logic bitstuff;
      logic dma;
      logic turnaround;
      logic field_size;
      logic data_crc;
      logic token_crc;  // device role source of bit 1
      logic frame_end;  // host role source of bit 1
      logic pid;
   } uevp_err_evt_type;

   // token presented by the packet engine
   typedef struct packed {
      logic       valid;
      logic       setup;
      logic       is_in;  // device sends data
      logic [3:0] ep;
   } uevp_token_type;

   // verdict on a token, one cycle later
   typedef struct packed {
      logic valid;
      logic rx_ok;
      logic tx_ok;
      logic setup_ok;
      logic stalled;
      logic handshake;
   } uevp_verdict_type;

endpackage

/* File: tb/uevp_link_model.sv */
`timescale 1ns/1ps
// stand-in for the packet engine: error, token and stall pulses
module uevp_link_model
   import uevp_pkg::*;
(
   input  wire logic       mclk,
   output uevp_err_evt_type err_evt,
   output uevp_token_type   token,
   output logic             stall_evt,
   output logic [3:0]       stall_ep
);
   // idle at time zero
   initial
   begin
      err_evt   = '0;
      token     = '0;
      stall_evt = 1'b0;
      stall_ep  = 4'hA;
   end
   // one-cycle error pulse, k counts struct bits from the lsb
   task automatic send_err(input int k);
      repeat ($urandom % 3) @(posedge mclk);
      @(posedge mclk);
      err_evt <= uevp_err_evt_type'(8'h01 << k);
      @(posedge mclk);
      err_evt <= '0;
   endtask
   // qualifiers are scrambled once valid drops, so a stale value never helps
   task automatic send_token(input logic [3:0] ep, input logic setup, input logic is_in);
      repeat ($urandom % 3) @(posedge mclk);
      @(posedge mclk);
      token <= '{1'b1, setup, is_in, ep};
      @(posedge mclk);
      token <= '{1'b0, ~setup, ~is_in, ~ep};
   endtask
   // stall report for one endpoint
   task automatic send_stall(input logic [3:0] ep);
      @(posedge mclk);
      stall_evt <= 1'b1;
      stall_ep  <= ep;
      @(posedge mclk);
      stall_evt <= 1'b0;
      stall_ep  <= ~ep;
   endtask
endmodule

/* File: tb/tb_usb_endpoint_error_enable_vbus_pwm.sv */
`timescale 1ns/1ps
module tb_usb_endpoint_error_enable_vbus_pwm
   import uevp_pkg::*;
;
   logic             mclk     = 1'b0;
   logic             rst      = 1'b1;
   logic             wb_cyc_i = 1'b0;
   logic             wb_stb_i = 1'b0;
   logic             wb_we_i  = 1'b0;
   logic [7:0]       wb_adr_i = 8'h00;
   logic [3:0]       wb_sel_i = 4'h0;
   logic [31:0]      wb_dat_i = 32'h00000000;
   logic [31:0]      wb_dat_o;
   logic             wb_ack_o;
   uevp_err_evt_type err_evt;
   uevp_token_type   token;
   logic             stall_evt;
   logic [3:0]       stall_ep;
   uevp_verdict_type verdict;
   logic             summ;
   logic             lsdc;
   logic             nakd;
   logic             pwm;
   logic             irq;
   logic [31:0]      q;                          // last read data
   int               miscompares = 0;
   int               check_count = 0;
   int               cyc_n       = 0;
   int               map [8]     = '{0, 1, 1, 2, 3, 4, 5, 7}; // event to flag bit

   always #50 mclk = ~mclk;

   uevp_top dut (.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .err_evt(err_evt), .token(token),
      .stall_evt(stall_evt), .stall_ep(stall_ep), .verdict(verdict),
      .usb_error_summary_flag(summ), .low_speed_direct_connect(lsdc),
      .nak_retry_disable(nakd), .vbus_pwm_out(pwm), .irq(irq));

   uevp_link_model link (.mclk(mclk), .err_evt(err_evt), .token(token),
      .stall_evt(stall_evt), .stall_ep(stall_ep));

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic fail(input string m);
      miscompares++;
      $display("CHECK FAILED t=%0t %s", $time, m);
   endtask

   // ceiling far above the expected few thousand cycles
   always @(posedge mclk)
   begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 40000)
      begin
         fail("timeout");
         stop_test();
      end
   end

   task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
         fail($sformatf("reg got %h exp %h", got, exp));
   endtask

   // masked compare of output levels or a verdict
   task automatic check_pin(input logic [5:0] got, input logic [5:0] exp,
                            input logic [5:0] msk = 6'h3F);
      check_count++;
      if ((got & msk) !== (exp & msk))
         fail($sformatf("pin got %h exp %h", got, exp));
   endtask

   // classic cycle: held until ack is sampled, released at that edge
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'h3;
      wb_dat_i <= d;
      @(posedge mclk);
      while (wb_ack_o !== 1'b1 && n < 20)
      begin
         @(posedge mclk);
         n++;
      end
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n == 20)
         fail("no ack");
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h00000000);
      check_reg(q, exp);
   endtask

   task automatic settle();
      repeat (3) @(posedge mclk);
   endtask

   // main sequence
   initial
   begin
      int   en, b, v, ep, s, i, h, k, n, d;
      logic e;
      logic lv;
      void'($urandom(72));
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      // reset state
      rd(UEVP_ADR_ERR_EN, 16'h0000);
      rd(UEVP_ADR_PWM_CTRL, 16'h0000);
      for (i = 0; i < 16; i++)
         rd(UEVP_ADR_EP_BASE + 8'(4 * i), 16'h0000);
      check_pin({irq, summ, lsdc, nakd, pwm, 1'b0}, 6'h00);
      $display("test reset done");
      // unimplemented bits, endpoint 0 extras only in host role
      wr(UEVP_ADR_MODE, 16'h0001);
      wr(UEVP_ADR_ERR_EN, 32'hFFFFFFFF);
      rd(UEVP_ADR_ERR_EN, 16'h00BF);
      wr(UEVP_ADR_PWM_CTRL, 32'hFFFF7CFF);
      rd(UEVP_ADR_PWM_CTRL, 16'h0000);
      for (i = 0; i < 16; i++)
      begin
         wr(UEVP_ADR_EP_BASE + 8'(4 * i), 32'hFFFFFFFF);
         rd(UEVP_ADR_EP_BASE + 8'(4 * i), (i == 0) ? 16'h00DF : 16'h001F);
      end
      wr(UEVP_ADR_MODE, 16'h0000);
      rd(UEVP_ADR_EP_BASE, 16'h001F);
      settle();
      check_pin({lsdc, nakd}, 6'h00);
      wr(8'hFC, 32'hFFFFFFFF);
      rd(8'hFC, 16'h0000);
      // host role outputs of endpoint 0
      wr(UEVP_ADR_MODE, 16'h0001);
      wr(UEVP_ADR_EP_BASE, 16'h0040);
      settle();
      check_pin({lsdc, nakd}, 6'h01);
      wr(UEVP_ADR_EP_BASE, 16'h0080);
      settle();
      check_pin({lsdc, nakd}, 6'h02);
      $display("test registers done");
      // every error source in both roles against a random enable
      wr(UEVP_ADR_IRQ_MASK, 16'h0001);
      for (h = 0; h < 2; h++)
         for (k = 0; k < 8; k++)
         begin
            en = $urandom & 32'h000000BF;
            wr(UEVP_ADR_MODE, 32'(h));
            wr(UEVP_ADR_ERR_FLAG, 16'h00FF);
            wr(UEVP_ADR_ERR_EN, 32'(en));
            wb(1'b0, UEVP_ADR_IRQ_STAT, 32'h00000000);
            link.send_err(k);
            settle();
            b = ((k == 1 && h == 0) || (k == 2 && h == 1)) ? -1 : map[k];
            e = (b >= 0) && en[b];
            check_pin(6'(summ), 6'(e));
            check_pin(6'(irq), 6'(e));
            rd(UEVP_ADR_ERR_FLAG, (b >= 0) ? (32'h1 << b) : 32'h0);
            rd(UEVP_ADR_IRQ_STAT, 32'(e));
         end
      $display("test errors done");
      // random endpoint setups against the token verdict
      wr(UEVP_ADR_MODE, 16'h0001);
      wr(UEVP_ADR_IRQ_MASK, 16'h0000);
      for (i = 0; i < 48; i++)
      begin
         ep = $urandom % 16;
         v  = $urandom & 32'h0000001D;
         s  = $urandom % 2;
         lv = (s == 0) && ($urandom % 2);
         wr(UEVP_ADR_EP_BASE + 8'(4 * ep), 32'(v));
         link.send_token(4'(ep), s[0], lv);
         @(posedge mclk);
         check_pin(verdict, {1'b1, v[3] & !s[0] & !lv, v[2] & lv, !v[4], 1'b0, v[0]},
                   (s[0] & v[3] & v[2]) ? 6'h3F : 6'h3B);
      end
      // refused setup raises, then a status read clears, the interrupt
      wb(1'b0, UEVP_ADR_IRQ_STAT, 32'h00000000);
      wr(UEVP_ADR_IRQ_MASK, 16'h0004);
      wr(UEVP_ADR_EP_BASE + 8'h0C, 16'h001C);
      link.send_token(4'h3, 1'b1, 1'b0);
      @(posedge mclk);
      check_pin(verdict, 6'h20, 6'h24);
      settle();
      check_pin(6'(irq), 6'h01);
      rd(UEVP_ADR_IRQ_STAT, 16'h0004);
      settle();
      check_pin(6'(irq), 6'h00);
      wr(UEVP_ADR_EP_BASE + 8'h0C, 16'h000C);
      link.send_token(4'h3, 1'b1, 1'b0);
      @(posedge mclk);
      check_pin(verdict, 6'h24, 6'h24);
      // stall report shows in the register and the verdict
      wr(UEVP_ADR_EP_BASE + 8'h14, 16'h000C);
      link.send_stall(4'h5);
      settle();
      rd(UEVP_ADR_EP_BASE + 8'h14, 16'h000E);
      link.send_token(4'h5, 1'b0, 1'b1);
      @(posedge mclk);
      check_pin(verdict, 6'h22, 6'h22);
      rd(UEVP_ADR_IRQ_STAT, 16'h0002);
      $display("test endpoints done");
      // generator idle levels, duty in both polarities, frozen counter
      wr(UEVP_ADR_PWM_CTRL, 16'h0000);
      settle();
      check_pin(6'(pwm), 6'h00);
      wr(UEVP_ADR_PWM_CTRL, 16'h0200);
      settle();
      check_pin(6'(pwm), 6'h01);
      d = 1 + $urandom % 255;
      wr(UEVP_ADR_PWM_DUTY, 32'(d));
      for (h = 0; h < 2; h++)
      begin
         wr(UEVP_ADR_PWM_CTRL, (h == 0) ? 16'h8100 : 16'h8300);
         settle();
         n = 0;
         repeat (256)
         begin
            @(posedge mclk);
            n += (pwm === (h == 0));
         end
         check_reg(n, d);
      end
      wr(UEVP_ADR_PWM_CTRL, 16'h8200);
      settle();
      lv = pwm;
      n  = 0;
      repeat (64)
      begin
         @(posedge mclk);
         n += (pwm !== lv);
      end
      check_reg(n, 0);
      $display("test generator done");
      stop_test();
   end
endmodule
